/* File: logic/wdt_pkg.sv */
// Constants, register map and types for the windowed watchdog.
// Assumes a 32-bit APB slave with word-aligned registers.
package wdt_pkg;
    // Register indices; byte address is four times the index
    localparam logic [9:0]  IDX_CTRL     = 10'h000;
    localparam logic [9:0]  IDX_STATUS   = 10'h001;
    localparam logic [11:0] ADDR_CTRL    = {IDX_CTRL, 2'b00};
    localparam logic [11:0] ADDR_STATUS  = {IDX_STATUS, 2'b00};

    // Field layout
    localparam int          PERIOD_LSB   = 0;
    localparam int          CLOSED_LSB   = 4;
    localparam int          FREEZE_BIT   = 7;
    localparam int          PEND_BIT     = 0;

    // Period codes and tick counts
    localparam logic [3:0]  CODE_OFF     = 4'h0;
    localparam logic [3:0]  CODE_MAX     = 4'hb;
    localparam logic [13:0] BASE_TICKS   = 14'h0008;

    // Unlock window in instructions, crossing depth in ticks
    localparam logic [2:0]  UNLOCK_INSTR = 3'h4;
    localparam logic [1:0]  SYNC_TICKS   = 2'h3;

    // Tick rate of the watchdog clock in Hz
    localparam int          TICK_HZ      = 1024;

    typedef enum logic [2:0] {
        st_off    = 3'b000,
        st_normal = 3'b001,
        st_arm    = 3'b010,
        st_closed = 3'b011,
        st_open   = 3'b100
    } wdt_state_t;

    // Ticks for a period code; zero for off and reserved codes
    function automatic logic [13:0] period_ticks(input logic [3:0] code);
        logic [3:0] sh;
        sh = code - 4'h1;
        if (code == CODE_OFF || code > CODE_MAX) begin
            period_ticks = 14'h0000;
        end else begin
            period_ticks = BASE_TICKS << sh;
        end
    endfunction
endpackage

/* File: logic/tick_enable.sv */
// Turns the asynchronous watchdog tick pin into a one-cycle enable.
// Assumes the tick is far slower than pclk.
`timescale 1ns/1ps
module tick_enable (
    // Clock and reset
    input  wire logic pclk,
    input  wire logic presetn,
    // Tick pin and enable
    input  wire logic tick_pin,
    output logic      tick_en
);
    logic meta_r;
    logic sync_r;
    logic last_r;

    // Only sync_r and last_r feed the edge detector
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            meta_r  <= 1'b0;
            sync_r  <= 1'b0;
            last_r  <= 1'b0;
            tick_en <= 1'b0;
        end else begin
            meta_r  <= tick_pin;
            sync_r  <= meta_r;
            last_r  <= sync_r;
            tick_en <= sync_r & ~last_r;
        end
    end
endmodule // tick_enable

/* File: logic/tick_delay.sv */
// Models a crossing into the watchdog domain: busy for a fixed count of
// ticks after start, then one done pulse.
// Assumes start is ignored by the caller's intent while busy.
`timescale 1ns/1ps
module tick_delay
    import wdt_pkg::*;
(
    // Clock and reset
    input  wire logic pclk,
    input  wire logic presetn,
    // Request and tick
    input  wire logic start,
    input  wire logic tick_en,
    // Progress
    output logic      busy,
    output logic      done
);
    logic [1:0] cnt_r;
    wire        last_tick = tick_en & (cnt_r == SYNC_TICKS - 2'h1);

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            busy  <= 1'b0;
            done  <= 1'b0;
            cnt_r <= 2'h0;
        end else begin
            done <= busy & last_tick;
            if (!busy && start) begin
                busy  <= 1'b1;
                cnt_r <= 2'h0;
            end else if (busy && last_tick) begin
                busy <= 1'b0;
            end else if (busy && tick_en) begin
                cnt_r <= cnt_r + 2'h1;
            end
        end
    end
endmodule // tick_delay

/* File: logic/windowed_watchdog_timer.sv */
// Windowed watchdog: APB registers, unlock window, freeze bit and the
// tick counter with normal and window modes.
// Assumes restart, unlock, instruction and debug strobes come from pclk
// logic; the tick pin and fuse are outside signals.
//
// What this block does
// - timeout_select codes 1..11 enable the watchdog
// - Normal mode: missed restart before time-out resets
// - Restart clears counter, fresh period begins
// - Eleven periods from about 8 ms to 8 s
// - Codes 1..11 give 8..8192 ticks, 0 off
// - Counter advances on the 1.024 kHz tick
// - closed_span_select 1..11 window, zero or other codes normal
// - Restart inside closed period resets immediately
// - Open period follows closed; restart needed there
// - Window sequence starts after first restart
// - Keeps counting while its tick runs
// - Debug halt stops and clears the counter
// - Resume from halt runs one normal time-out
// - Control writes cross domains; sync_pending shows it
// - sync_pending clears when crossing completes
// - Restart takes two to three ticks to cross
// - Protected write only within four instructions of key
// - Unprotected writes to protected registers ignored
// - Control and settings_freeze are protected
// - Freeze blocks control; cleared only in debug
// - Control loads from fuse; non-zero period freezes
`timescale 1ns/1ps
module windowed_watchdog_timer
    import wdt_pkg::*;
(
    // Clock and reset
    input  wire logic        pclk,
    input  wire logic        presetn,
    // APB slave
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [11:0] paddr,
    input  wire logic [31:0] pwdata,
    input  wire logic [3:0]  pstrb,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    // Processor strobes
    input  wire logic        restart_req,
    input  wire logic        unlock_key_pulse,
    input  wire logic        instr_done,
    input  wire logic        debug_halt,
    // Fuse and tick pin
    input  wire logic [7:0]  fuse_config,
    input  wire logic        tick_pin,
    // Reset request
    output logic             system_reset
);
    import wdt_pkg::*;

    logic [7:0]  ctrl_r;
    logic        freeze_r;
    logic        boot_r;
    logic [2:0]  unlock_cnt_r;
    logic [2:0]  unlock_cnt_nxt;
    logic [3:0]  act_period_r;
    logic [3:0]  act_closed_r;
    logic [13:0] cnt_r;
    logic [13:0] cnt_nxt;
    wdt_state_t  state_r;
    wdt_state_t  state_nxt;
    logic        fire;
    logic        tick_en;
    logic        sync_pending;
    logic        cfg_done;
    logic        rs_busy;
    logic        rs_done;
    logic [1:0]  rs_ticks_r;

    // Bus decode
    wire        setup_ph   = psel & ~penable;
    wire        wr_acc     = psel & penable & pwrite & pready;
    wire        hit_ctrl   = (paddr == ADDR_CTRL);
    wire        hit_stat   = (paddr == ADDR_STATUS);
    wire        mapped     = hit_ctrl | hit_stat;
    wire        lane0      = pstrb[0];
    wire        wr_ctrl    = wr_acc & hit_ctrl & lane0;
    wire        wr_stat    = wr_acc & hit_stat & lane0;
    wire        unlocked   = (unlock_cnt_r != 3'h0);

    // Writes made while pending are dropped so the crossing sees one value
    wire        ctrl_ok    = wr_ctrl & unlocked & ~freeze_r
                             & ~sync_pending & ~boot_r;
    wire        freeze_set = wr_stat & unlocked & pwdata[FREEZE_BIT];
    wire        freeze_clr = wr_stat & unlocked & ~pwdata[FREEZE_BIT]
                             & debug_halt;

    wire [7:0]  stat_val   = {freeze_r, 6'h00, sync_pending};
    wire [31:0] rd_val     = hit_ctrl ? {24'h000000, ctrl_r}
                           : hit_stat ? {24'h000000, stat_val}
                                      : 32'h00000000;

    // Configuration source: fuse at boot, control after a crossing
    wire        apply      = boot_r | cfg_done;
    wire [7:0]  cfg_src    = boot_r ? fuse_config : ctrl_r;
    wire [3:0]  src_period = cfg_src[PERIOD_LSB +: 4];
    wire [3:0]  src_closed = cfg_src[CLOSED_LSB +: 4];
    wire [13:0] src_open_t = period_ticks(src_period);
    wire [13:0] src_clos_t = period_ticks(src_closed);

    // Active limits in the watchdog domain
    wire [13:0] lim_open   = period_ticks(act_period_r);
    wire [13:0] lim_closed = period_ticks(act_closed_r);
    wire        window_on  = (lim_closed != 14'h0000);
    wire [13:0] cnt_inc    = cnt_r + 14'h0001;

    // Restart crossing; a second restart while one is in flight merges
    wire        rs_start   = restart_req & ~debug_halt;

    tick_enable u_tick (
        .pclk     (pclk),
        .presetn  (presetn),
        .tick_pin (tick_pin),
        .tick_en  (tick_en)
    );

    tick_delay u_cfg_sync (
        .pclk    (pclk),
        .presetn (presetn),
        .start   (ctrl_ok),
        .tick_en (tick_en),
        .busy    (sync_pending),
        .done    (cfg_done)
    );

    tick_delay u_rs_sync (
        .pclk    (pclk),
        .presetn (presetn),
        .start   (rs_start),
        .tick_en (tick_en),
        .busy    (rs_busy),
        .done    (rs_done)
    );

    // Unlock window counts instructions after the key
    always_comb begin
        unlock_cnt_nxt = unlock_cnt_r;
        if (unlock_key_pulse) begin
            unlock_cnt_nxt = UNLOCK_INSTR;
        end else if (instr_done && unlocked) begin
            unlock_cnt_nxt = unlock_cnt_r - 3'h1;
        end
    end

    // Watchdog phase sequencing
    always_comb begin
        state_nxt = state_r;
        cnt_nxt   = cnt_r;
        fire      = 1'b0;
        if (apply) begin
            cnt_nxt = 14'h0000;
            if (src_open_t == 14'h0000) begin
                state_nxt = st_off;
            end else if (src_clos_t != 14'h0000) begin
                state_nxt = st_arm;
            end else begin
                state_nxt = st_normal;
            end
        end else if (debug_halt) begin
            cnt_nxt = 14'h0000;
            if (state_r != st_off) begin
                state_nxt = window_on ? st_arm : st_normal;
            end
        end else begin
            case (state_r)
                st_normal, st_arm, st_open: begin
                    if (rs_done) begin
                        cnt_nxt   = 14'h0000;
                        state_nxt = window_on ? st_closed : st_normal;
                    end else if (tick_en) begin
                        if (cnt_inc >= lim_open) begin
                            fire = 1'b1;
                        end else begin
                            cnt_nxt = cnt_inc;
                        end
                    end
                end
                st_closed: begin
                    if (rs_done) begin
                        fire = 1'b1;
                    end else if (tick_en) begin
                        if (cnt_inc >= lim_closed) begin
                            cnt_nxt   = 14'h0000;
                            state_nxt = st_open;
                        end else begin
                            cnt_nxt = cnt_inc;
                        end
                    end
                end
                st_off: begin
                    cnt_nxt = 14'h0000;
                end
                default: begin
                    state_nxt = st_off;
                end
            endcase
        end
    end

    // Bus answer: zero wait states, data and error captured in setup
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready  <= 1'b0;
            prdata  <= 32'h00000000;
            pslverr <= 1'b0;
        end else begin
            pready <= 1'b1;
            if (setup_ph) begin
                prdata  <= pwrite ? 32'h00000000 : rd_val;
                pslverr <= ~mapped;
            end
        end
    end

    // Software-visible registers; the fuse is caught at the first edge
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            boot_r       <= 1'b1;
            ctrl_r       <= 8'h00;
            freeze_r     <= 1'b0;
            unlock_cnt_r <= 3'h0;
        end else begin
            boot_r       <= 1'b0;
            unlock_cnt_r <= unlock_cnt_nxt;
            if (boot_r) begin
                ctrl_r   <= fuse_config;
                freeze_r <= (fuse_config[PERIOD_LSB +: 4] != CODE_OFF);
            end else begin
                if (ctrl_ok) begin
                    ctrl_r <= pwdata[7:0];
                end
                if (freeze_set) begin
                    freeze_r <= 1'b1;
                end else if (freeze_clr) begin
                    freeze_r <= 1'b0;
                end
            end
        end
    end

    // Watchdog-side state; the reset request holds until system reset
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            act_period_r <= CODE_OFF;
            act_closed_r <= CODE_OFF;
            state_r      <= st_off;
            cnt_r        <= 14'h0000;
            system_reset <= 1'b0;
        end else begin
            if (apply) begin
                act_period_r <= src_period;
                act_closed_r <= src_closed;
            end
            state_r      <= state_nxt;
            cnt_r        <= cnt_nxt;
            system_reset <= system_reset | fire;
        end
    end

    // Ticks seen by the restart crossing, kept only for the latency check
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rs_ticks_r <= 2'h0;
        end else if (!rs_busy) begin
            rs_ticks_r <= 2'h0;
        end else if (tick_en) begin
            rs_ticks_r <= rs_ticks_r + 2'h1;
        end
    end

    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);

    AST_EN_NEEDS_PERIOD: assert property (
        (state_r != st_off && !boot_r) |-> (lim_open != 14'h0000))
        else $error("watchdog running with period off");

    AST_NORMAL_TIMEOUT: assert property (
        (state_r == st_normal && tick_en && cnt_inc == lim_open && !rs_done
         && !debug_halt && !apply) |=> system_reset)
        else $error("missed time-out did not reset");

    AST_RESTART_CLEARS: assert property (
        (state_r == st_normal && rs_done && !debug_halt && !apply)
        |=> (cnt_r == 14'h0000 && state_r == st_normal))
        else $error("restart did not clear counter");

    AST_CLOSED_RESTART: assert property (
        (state_r == st_closed && rs_done && !debug_halt && !apply)
        |=> system_reset)
        else $error("early restart did not reset");

    AST_CLOSED_TO_OPEN: assert property (
        (state_r == st_closed && tick_en && cnt_inc == lim_closed
         && !rs_done && !debug_halt && !apply)
        |=> (state_r == st_open && cnt_r == 14'h0000))
        else $error("open period did not follow closed");

    AST_HALT_CLEARS: assert property (
        (debug_halt && !apply) |=> (cnt_r == 14'h0000 && state_r != st_closed))
        else $error("halt did not clear counter");

    AST_SYNC_FLAG: assert property (
        ctrl_ok |=> sync_pending [*2])
        else $error("sync_pending not raised after write");

    AST_SYNC_DONE: assert property (
        cfg_done |-> (!sync_pending && $past(sync_pending)))
        else $error("crossing done without pending");

    AST_FROZEN_HOLD: assert property (
        (freeze_r && !boot_r) |=> $stable(ctrl_r))
        else $error("control changed while frozen");

    AST_LOCKED_WRITE: assert property (
        (wr_ctrl && !unlocked && !boot_r) |=> $stable(ctrl_r))
        else $error("unprotected write changed control");

    AST_RESTART_LATENCY: assert property (
        (rs_start && !rs_busy) |=> !rs_done [*2])
        else $error("restart crossed too quickly");

    AST_BOOT_FROM_FUSE: assert property (
        $fell(boot_r) |-> (ctrl_r == $past(fuse_config)
                           && freeze_r == (ctrl_r[PERIOD_LSB +: 4] != CODE_OFF)))
        else $error("boot did not load the fuse setting");

    AST_CFG_APPLIED: assert property (
        (cfg_done && !boot_r) |=> ({act_closed_r, act_period_r} == $past(ctrl_r)))
        else $error("crossed setting not applied");

    AST_FREEZE_CLEAR_HALT: assert property (
        $fell(freeze_r) |-> $past(debug_halt))
        else $error("freeze cleared outside debug halt");

    AST_RESET_HOLDS: assert property (
        system_reset |=> system_reset)
        else $error("reset request dropped");

    AST_UNLOCK_CLOSES: assert property (
        (instr_done && !unlock_key_pulse && unlock_cnt_r == 3'h1)
        |=> !unlocked)
        else $error("unlock window outlived four instructions");

    AST_RESTART_TICKS: assert property (
        rs_done |-> (rs_ticks_r == SYNC_TICKS))
        else $error("restart crossing took the wrong tick count");

    COV_NORMAL_FIRE: cover property (state_r == st_normal && fire);
    COV_RESUME_ARM:  cover property ($fell(debug_halt) && state_r == st_arm);
    COV_WINDOW_OPEN: cover property (state_r == st_open && rs_done);
    COV_EARLY_FIRE:  cover property (state_r == st_closed && fire);
    COV_FREEZE_SET:  cover property (freeze_set);
endmodule // windowed_watchdog_timer

/* File: testbench/tb_windowed_watchdog_timer.sv */
// Self-checking bench for the windowed watchdog: APB register access,
// unlock window, freeze bit, normal and window time-outs, debug halt.
// Assumes the design package and the watchdog top module are compiled first.
`timescale 1ns/1ps
module tb_windowed_watchdog_timer;
    import wdt_pkg::*;

    logic        pclk;
    logic        presetn;
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [11:0] paddr;
    logic [31:0] pwdata;
    logic [3:0]  pstrb;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
    logic        restart_req;
    logic        unlock_key_pulse;
    logic        instr_done;
    logic        debug_halt;
    logic [7:0]  fuse_config;
    logic        tick_pin = 1'b0;
    logic        system_reset;
    logic [4:0]  tcnt     = 5'd0;
    logic [31:0] rd_v;
    logic        err_v;
    int          bad_count;
    int          n_tests;
    int          seed;
    int          code;
    int          n;
    logic [31:0] v;

    // Strobe selectors for pulse
    localparam int P_RESTART = 0;
    localparam int P_KEY     = 1;
    localparam int P_INSTR   = 2;

    windowed_watchdog_timer DUT (
        .pclk             (pclk),
        .presetn          (presetn),
        .psel             (psel),
        .penable          (penable),
        .pwrite           (pwrite),
        .paddr            (paddr),
        .pwdata           (pwdata),
        .pstrb            (pstrb),
        .prdata           (prdata),
        .pready           (pready),
        .pslverr          (pslverr),
        .restart_req      (restart_req),
        .unlock_key_pulse (unlock_key_pulse),
        .instr_done       (instr_done),
        .debug_halt       (debug_halt),
        .fuse_config      (fuse_config),
        .tick_pin         (tick_pin),
        .system_reset     (system_reset)
    );

    initial begin
        pclk = 1'b0;
        forever #2.5 pclk = ~pclk;
    end

    // Tick pin runs far faster than the real oscillator to keep the run short
    always @(posedge pclk) begin
        tcnt     <= (tcnt == 5'd19) ? 5'd0 : tcnt + 5'd1;
        tick_pin <= (tcnt < 5'd4);
    end

    function automatic int exp_ticks(input int c);
        exp_ticks = 8 << (c - 1);
    endfunction

    task automatic check(input logic [31:0] got, input logic [31:0] exp, input string msg);
        n_tests++;
        if (got !== exp) begin
            bad_count++;
            $display("CHECK FAILED at %0t: %s got %h expected %h", $time, msg, got, exp);
        end
    endtask

    task automatic tally_and_finish;
        if (bad_count == 0 && n_tests > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask

    // Request held until pready is seen high at a rising edge
    task automatic apb_xfer(input logic w, input logic [11:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= w;
        paddr   <= a;
        pwdata  <= d;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1) @(posedge pclk);
        rd_v = prdata;
        err_v = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask

    // One processor strobe high for exactly one clock
    task automatic pulse(input int sel);
        @(posedge pclk);
        restart_req      <= (sel == P_RESTART);
        unlock_key_pulse <= (sel == P_KEY);
        instr_done       <= (sel == P_INSTR);
        @(posedge pclk);
        {restart_req, unlock_key_pulse, instr_done} <= 3'h0;
    endtask

    task automatic wait_ticks(input int k);
        repeat (k) @(posedge tick_pin);
    endtask

    task automatic do_reset(input logic [7:0] f);
        @(posedge pclk);
        presetn     <= 1'b0;
        fuse_config <= f;
        debug_halt  <= 1'b0;
        repeat (12) @(posedge pclk);
        presetn <= 1'b1;
        repeat (2) @(posedge pclk);
    endtask

    task automatic prot_write(input logic [11:0] a, input logic [31:0] d);
        pulse(P_KEY);
        apb_xfer(1'b1, a, d);
    endtask

    task automatic set_ctrl(input logic [7:0] c);
        prot_write(ADDR_CTRL, {24'h0, c});
        apb_xfer(1'b0, ADDR_STATUS, 32'h0);
        check({31'h0, rd_v[PEND_BIT]}, 32'h1, "pending after write");
        n = 0;
        while (rd_v[PEND_BIT] !== 1'b0 && n < 400) begin
            apb_xfer(1'b0, ADDR_STATUS, 32'h0);
            n++;
        end
        check({31'h0, rd_v[PEND_BIT]}, 32'h0, "pending cleared");
    endtask

    initial begin
        repeat (60000) @(posedge pclk);
        bad_count++;
        tally_and_finish;
    end

    initial begin
        seed = 74440;
        bad_count = 0;
        n_tests = 0;
        presetn = 1'b0;
        {psel, penable, pwrite, restart_req, unlock_key_pulse, instr_done} = 6'h0;
        {paddr, pwdata, pstrb, debug_halt} = '0;
        pstrb = 4'hf;
        fuse_config = 8'h00;
        do_reset(8'h00);
        apb_xfer(1'b0, ADDR_CTRL, 32'h0);
        check(rd_v, 32'h0, "ctrl from zero fuse");
        apb_xfer(1'b1, ADDR_CTRL, 32'h01);
        apb_xfer(1'b0, ADDR_CTRL, 32'h0);
        check(rd_v, 32'h0, "write without key");
        pulse(P_KEY);
        repeat (4) pulse(P_INSTR);
        apb_xfer(1'b1, ADDR_CTRL, 32'h01);
        apb_xfer(1'b0, ADDR_CTRL, 32'h0);
        check(rd_v, 32'h0, "write after window closed");
        apb_xfer(1'b0, 12'h008, 32'h0);
        check({31'h0, err_v}, 32'h1, "unmapped error");
        check(rd_v, 32'h0, "unmapped data");
        for (int i = 0; i < 4; i++) begin
            v = $random(seed);
            set_ctrl(v[7:0]);
            apb_xfer(1'b0, ADDR_CTRL, 32'h0);
            check(rd_v, {24'h0, v[7:0]}, "ctrl readback");
        end
        // Normal-mode time-out for the shortest codes
        for (code = 1; code <= 3; code++) begin
            do_reset(8'h00);
            set_ctrl(code[7:0]);
            // The last tick of a period is counted a few clocks after its pin edge
            wait_ticks(exp_ticks(code));
            check({31'h0, system_reset}, 32'h0, "early reset");
            wait_ticks(1);
            check({31'h0, system_reset}, 32'h1, "missed time-out");
        end
        do_reset(8'h00);
        set_ctrl(8'h01);
        repeat (6) begin
            wait_ticks(4);
            pulse(P_RESTART);
        end
        check({31'h0, system_reset}, 32'h0, "restart keeps alive");
        debug_halt <= 1'b1;
        wait_ticks(20);
        check({31'h0, system_reset}, 32'h0, "halt stops counter");
        debug_halt <= 1'b0;
        wait_ticks(12);
        check({31'h0, system_reset}, 32'h1, "counts after resume");
        // Early restart inside the closed window
        do_reset(8'h00);
        set_ctrl(8'h21);
        pulse(P_RESTART);
        wait_ticks(5);
        check({31'h0, system_reset}, 32'h0, "first restart arms");
        wait_ticks(4);
        pulse(P_RESTART);
        wait_ticks(5);
        check({31'h0, system_reset}, 32'h1, "closed restart");
        // Restart inside the open window
        do_reset(8'h00);
        set_ctrl(8'h21);
        pulse(P_RESTART);
        wait_ticks(20);
        pulse(P_RESTART);
        wait_ticks(8);
        check({31'h0, system_reset}, 32'h0, "open restart");
        wait_ticks(24);
        check({31'h0, system_reset}, 32'h1, "open window missed");
        // Resume from halt skips the closed window
        do_reset(8'h00);
        set_ctrl(8'h21);
        pulse(P_RESTART);
        wait_ticks(6);
        debug_halt <= 1'b1;
        wait_ticks(4);
        debug_halt <= 1'b0;
        pulse(P_RESTART);
        wait_ticks(6);
        check({31'h0, system_reset}, 32'h0, "resume restart");
        // Freeze set, blocks control, cleared only under halt
        do_reset(8'h00);
        prot_write(ADDR_STATUS, 32'h80);
        apb_xfer(1'b0, ADDR_STATUS, 32'h0);
        check({31'h0, rd_v[FREEZE_BIT]}, 32'h1, "freeze set");
        // Status is non-zero now, so an unmapped read must not echo it
        apb_xfer(1'b0, 12'h008, 32'h0);
        check(rd_v, 32'h0, "unmapped data while frozen");
        prot_write(ADDR_CTRL, 32'h03);
        apb_xfer(1'b0, ADDR_CTRL, 32'h0);
        check(rd_v, 32'h0, "frozen ctrl");
        prot_write(ADDR_STATUS, 32'h00);
        apb_xfer(1'b0, ADDR_STATUS, 32'h0);
        check({31'h0, rd_v[FREEZE_BIT]}, 32'h1, "clear outside halt");
        debug_halt <= 1'b1;
        prot_write(ADDR_STATUS, 32'h00);
        apb_xfer(1'b0, ADDR_STATUS, 32'h0);
        check({31'h0, rd_v[FREEZE_BIT]}, 32'h0, "clear in halt");
        // Non-zero fuse period boots enabled and frozen
        do_reset(8'h53);
        apb_xfer(1'b0, ADDR_CTRL, 32'h0);
        check(rd_v, 32'h53, "ctrl from fuse");
        apb_xfer(1'b0, ADDR_STATUS, 32'h0);
        check({31'h0, rd_v[FREEZE_BIT]}, 32'h1, "boot freeze");
        tally_and_finish;
    end
endmodule // tb_windowed_watchdog_timer
